// ===== csf_pkg.sv
package csf_pkg;

  // register commands
  localparam logic [7:0]  CMD_CONTROL      = 8'h12;
  localparam logic [7:0]  CMD_STATUS       = 8'h13;
  localparam logic [7:0]  CMD_CHARGE_VOLT  = 8'h15;
  localparam logic [15:0] CONTROL_RESET    = 16'h0000;
  localparam logic [15:0] CHARGE_VOLT_RESET = 16'h0000;

  // control fields
  localparam int CTRL_INHIBIT_BIT  = 0;
  localparam int CTRL_LEARN_BIT    = 4;
  localparam int CTRL_DEPL_LSB     = 9;
  localparam int CTRL_DEPL_MSB     = 11;

  // status bit positions
  localparam int ST_DEPLETED_BIT   = 11;
  localparam int ST_VOR_BIT        = 12;
  localparam int ST_ADP_LOW_BIT    = 13;
  localparam int ST_BATT_BIT       = 14;
  localparam int ST_ADP_BIT        = 15;

  // voltage figures in millivolts
  localparam logic [15:0] V_WAKE_MV   = 16'h2328;  // 9000
  localparam logic [15:0] V_3C_MIN_MV = 16'h2EE0;  // 12000
  localparam logic [15:0] V_3C_MAX_MV = 16'h3840;  // 14400
  localparam logic [15:0] V_4C_MIN_MV = 16'h3E80;  // 16000
  localparam logic [15:0] V_4C_MAX_MV = 16'h4B00;  // 19200
  localparam int          DAC_STEP_BITS = 4;       // 16 mV steps
  localparam logic [2:0]  CELLS_3 = 3'h3;
  localparam logic [2:0]  CELLS_4 = 3'h4;

  // per-cell depleted threshold: base plus step times select
  localparam logic [15:0] DEPL_BASE_MV = 16'h0A8C;  // 2700
  localparam logic [15:0] DEPL_STEP_MV = 16'h0064;  // 100

  // timing
  localparam int CLK_HZ          = 100_000_000;
  localparam int DEGLITCH_US     = 8000;
  localparam int ALERT_DELAY_US  = 8000;
  localparam int POR_RELEASE_US  = 1;
  localparam int DEGLITCH_CYC    = DEGLITCH_US * (CLK_HZ / 1_000_000);
  localparam int ALERT_DELAY_CYC = ALERT_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int POR_RELEASE_CYC = POR_RELEASE_US * (CLK_HZ / 1_000_000);
  localparam int TMR_W           = 20;

  // comparator bundle from the analog front end
  typedef struct packed {
    logic input_low;      // input within 150 mV of battery
    logic bat_above_acp;  // battery pin above adapter sense pin
    logic ts_below_det;   // thermistor pin below detect threshold
    logic adapter_detect_pin_2v4;      // adapter detect above 2.4 V
    logic adapter_detect_pin_1v2;      // adapter detect above 1.2 V
    logic vcc_6v5;        // supply above 6.5 V
  } csf_cmp_type;

  // status word, upper five bits owned here
  typedef struct packed {
    logic       adapter_present;
    logic       battery_present;
    logic       adapter_below_battery;
    logic       voltage_out_of_range;
    logic       battery_depleted;
    logic [10:0] lower;
  } csf_status_type;

endpackage

// ===== csf_charger_status.sv
`timescale 1ns/1ns
`default_nettype none
module csf_charger_status
  import csf_pkg::*;
#(
  parameter int unsigned DEGLITCH_CYCLES = DEGLITCH_CYC,
  parameter int unsigned ALERT_CYCLES    = ALERT_DELAY_CYC
)(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire csf_cmp_type cmp_pins,
  input  wire logic [15:0] battery_sense_mv,
  input  wire logic [7:0]  reg_cmd,
  input  wire logic        reg_wr_en,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_rd_en,
  output logic [15:0]      reg_rdata,
  output logic             reg_rd_valid,
  output logic             reg_cmd_ok,
  output logic             host_port_enable,
  output logic             charge_enable,
  output logic [15:0]      regulated_voltage_mv,
  output logic             battery_path_driver,
  output logic             adapter_path_driver,
  output logic             bypass_switch,
  output logic             five_volt_reference,
  output logic             alert
);

  ////////////////////////////////////////////////////////////////////////////
  // per-cell depleted threshold times cell count, cut to 16 bits
  function automatic logic [15:0] depl_threshold(input logic [2:0] sel,
                                                 input logic [2:0] cells);
    logic [31:0] per_cell;
    logic [31:0] total;
    per_cell = 32'(DEPL_BASE_MV) + 32'(DEPL_STEP_MV) * 32'(sel);
    total    = per_cell * 32'(cells);
    return total[15:0];
  endfunction

  // inclusive band test, shared by the three-cell and four-cell windows
  // so both ends of each window are treated alike
  function automatic logic in_band(input logic [15:0] v,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchroniser for the comparator pins
  csf_cmp_type cmp_meta_q;
  csf_cmp_type cmp_q;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cmp_meta_q <= '0;
      cmp_q      <= '0;
    end
    else
    begin
      cmp_meta_q <= cmp_pins;
      cmp_q      <= cmp_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // internal power-on reset, released a short while after both levels good
  // either level dropping restarts the wait, so a bouncing supply never
  // opens the host port half way; the counter stops once released
  logic                 supply_good;
  logic [TMR_W-1:0]     por_cnt_q;
  logic                 por_done_q;

  assign supply_good = cmp_q.adapter_detect_pin_1v2 && cmp_q.vcc_6v5;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      por_cnt_q  <= '0;
      por_done_q <= 1'b0;
    end
    else if (!supply_good)
    begin
      por_cnt_q  <= '0;
      por_done_q <= 1'b0;
    end
    else if (por_cnt_q == TMR_W'(POR_RELEASE_CYC - 1))
      por_done_q <= 1'b1;
    else
      por_cnt_q <= por_cnt_q + TMR_W'(1);
  end

  assign host_port_enable = por_done_q;

  ////////////////////////////////////////////////////////////////////////////
  // host registers; held at reset values while internal reset is active
  logic [15:0] control_q;
  logic [15:0] charge_volt_q;
  logic        wr_control;
  logic        wr_volt;
  logic        cmd_known;
  logic        sel_control;
  logic        sel_status;
  logic        sel_volt;

  // command decode shared by writes, reads, the ack hint and the alert clear
  assign sel_control = (reg_cmd == CMD_CONTROL);
  assign sel_status  = (reg_cmd == CMD_STATUS);
  assign sel_volt    = (reg_cmd == CMD_CHARGE_VOLT);

  // only whole words are seen here; byte pairing is the serial engine's job
  assign cmd_known  = sel_control || sel_status || sel_volt;
  assign wr_control = por_done_q && reg_wr_en && sel_control;
  assign wr_volt    = por_done_q && reg_wr_en && sel_volt;
  assign reg_cmd_ok = por_done_q && cmd_known;  // status write is ignored

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      control_q     <= CONTROL_RESET;
      charge_volt_q <= CHARGE_VOLT_RESET;
    end
    else if (!por_done_q)
    begin
      control_q     <= CONTROL_RESET;
      charge_volt_q <= CHARGE_VOLT_RESET;
    end
    else
    begin
      if (wr_control)
        control_q <= reg_wdata;
      if (wr_volt)
        charge_volt_q <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // charge-voltage range check, clamp and step rounding
  // all decisions come from the stored setting, so a write takes effect on
  // the next cycle; the regulation target itself is registered once more
  logic        v_wake;
  logic        v_3cell;
  logic        v_4cell;
  logic        v_above;
  logic        v_disable;
  logic        v_out_of_range;
  logic [15:0] v_clamped;
  logic [15:0] v_rounded;
  logic [2:0]  cell_count;

  assign v_wake    = (charge_volt_q == V_WAKE_MV);
  assign v_3cell   = in_band(charge_volt_q, V_3C_MIN_MV, V_3C_MAX_MV);
  assign v_4cell   = in_band(charge_volt_q, V_4C_MIN_MV, V_4C_MAX_MV);
  assign v_above   = (charge_volt_q > V_4C_MAX_MV);
  // below 12 V except wake, or in the 14.4-16 V gap
  assign v_disable = !v_wake && !v_3cell && !v_4cell && !v_above;
  assign v_out_of_range = !(v_wake || v_3cell || v_4cell);
  assign v_clamped = v_above ? V_4C_MAX_MV : charge_volt_q;
  // wake value kept exact, the rest truncated so the pack is never overcharged
  assign v_rounded = v_wake ? V_WAKE_MV
                   : {v_clamped[15:DAC_STEP_BITS], {DAC_STEP_BITS{1'b0}}};
  assign cell_count = (v_4cell || v_above) ? CELLS_4 : CELLS_3;

  ////////////////////////////////////////////////////////////////////////////
  // live status word built from synchronized comparators and range check
  // nothing here is latched: a read shows the levels of the same cycle as
  // the read strobe, and the lower eleven bits belong to other logic
  csf_status_type status_now;
  logic [15:0]    depl_mv;
  logic           batt_depleted;

  assign depl_mv       = depl_threshold(control_q[CTRL_DEPL_MSB:CTRL_DEPL_LSB],
                                        cell_count);
  assign batt_depleted = (battery_sense_mv < depl_mv);

  always_comb
  begin
    status_now                       = '0;
    status_now.battery_depleted      = batt_depleted;
    status_now.voltage_out_of_range  = v_out_of_range;
    status_now.adapter_below_battery = cmp_q.bat_above_acp;
    status_now.battery_present       = cmp_q.ts_below_det;
    status_now.adapter_present       = cmp_q.adapter_detect_pin_2v4;
  end

  ////////////////////////////////////////////////////////////////////////////
  // charge control and power path; charge_enable is combinational, path drivers registered, so a lost pack
  // stops charging in the same cycle the synchronizer shows it
  logic learn_mode;
  logic adp_present;
  logic adp_path;

  assign learn_mode  = control_q[CTRL_LEARN_BIT];
  assign adp_present = status_now.adapter_present;
  assign adp_path    = adp_present && (!learn_mode || batt_depleted);

  assign charge_enable = por_done_q
                      && adp_present
                      && status_now.battery_present
                      && !v_disable
                      && !control_q[CTRL_INHIBIT_BIT];
  assign five_volt_reference = adp_present;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      regulated_voltage_mv <= '0;
      battery_path_driver  <= 1'b0;
      adapter_path_driver  <= 1'b0;
    end
    else
    begin
      regulated_voltage_mv <= v_disable ? 16'h0000 : v_rounded;
      battery_path_driver  <= !batt_depleted && !adp_path;
      adapter_path_driver  <= adp_path;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bypass switch: off at once, on again only after a clean deglitch window
  // any single low-input sample restarts the window, which trades a slower
  // recovery for never closing the switch on a ringing input
  logic [TMR_W-1:0] byp_cnt_q;
  logic             byp_on_q;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      byp_cnt_q <= '0;
      byp_on_q  <= 1'b0;
    end
    else if (cmp_q.input_low)
    begin
      byp_cnt_q <= '0;
      byp_on_q  <= 1'b0;
    end
    else if (!byp_on_q)
    begin
      if (byp_cnt_q == TMR_W'(DEGLITCH_CYCLES - 1))
        byp_on_q <= 1'b1;
      else
        byp_cnt_q <= byp_cnt_q + TMR_W'(1);
    end
  end

  assign bypass_switch = byp_on_q;

  ////////////////////////////////////////////////////////////////////////////
  // alert: a toggle arms a fixed delay; one delay covers a burst of toggles
  // limitation: a toggle that lands while armed is not timed on its own,
  // it only rides on the pending alert
  logic [15:0]      status_prev_q;
  logic             toggled;
  logic             alert_armed_q;
  logic [TMR_W-1:0] alert_cnt_q;
  logic             alert_q;
  logic             alert_fire;
  logic             status_read;

  assign toggled     = (status_now != status_prev_q);
  assign alert_fire  = alert_armed_q && (alert_cnt_q == TMR_W'(ALERT_CYCLES - 1));
  assign status_read = por_done_q && reg_rd_en && sel_status;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      status_prev_q <= '0;
      alert_armed_q <= 1'b0;
      alert_cnt_q   <= '0;
    end
    else
    begin
      status_prev_q <= status_now;
      if (alert_fire)
      begin
        alert_armed_q <= 1'b0;
        alert_cnt_q   <= '0;
      end
      else if (alert_armed_q)
        alert_cnt_q <= alert_cnt_q + TMR_W'(1);
      else if (toggled)
        alert_armed_q <= 1'b1;
    end
  end

  // set wins over the clearing status read
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      alert_q <= 1'b0;
    else if (alert_fire)
      alert_q <= 1'b1;
    else if (status_read)
      alert_q <= 1'b0;
  end

  assign alert = alert_q;

  ////////////////////////////////////////////////////////////////////////////
  // read data, registered; unknown commands read as zero
  // the data holds between reads so a slow serial engine can shift it out
  // without a second strobe; reads before power-on give no valid pulse
  logic [15:0] rd_mux;

  assign rd_mux = sel_control ? control_q
                : sel_status  ? 16'(status_now)
                : sel_volt    ? charge_volt_q
                : 16'h0000;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      reg_rdata    <= '0;
      reg_rd_valid <= 1'b0;
    end
    else
    begin
      reg_rd_valid <= por_done_q && reg_rd_en;
      if (por_done_q && reg_rd_en)
        reg_rdata <= rd_mux;
    end
  end

endmodule
`default_nettype wire

// ===== csf_charger_status_checker.sv
`timescale 1ns/1ns
`default_nettype none
module csf_charger_status_checker
  import csf_pkg::*;
#(
  parameter int unsigned DEGLITCH_CYCLES = 50,
  parameter int unsigned ALERT_CYCLES    = 60
)(
  input wire logic        clk,
  input wire logic        resetn,
  input wire csf_cmp_type cmp_pins,
  input wire logic        reg_rd_en,
  input wire logic        reg_rd_valid,
  input wire logic        host_port_enable,
  input wire logic        charge_enable,
  input wire logic [15:0] regulated_voltage_mv,
  input wire logic        battery_path_driver,
  input wire logic        adapter_path_driver,
  input wire logic        bypass_switch,
  input wire logic        five_volt_reference,
  input wire logic        alert
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////
  // raw pin quiet time and uptime; raw counts run ahead of the synced view
  logic [15:0] quiet_q;
  logic [15:0] up_q;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn) quiet_q <= 16'h0000;
    else if (cmp_pins.input_low) quiet_q <= 16'h0000;
    else if (quiet_q != 16'hFFFF) quiet_q <= quiet_q + 16'h0001;
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn) up_q <= 16'h0000;
    else if (up_q != 16'hFFFF) up_q <= up_q + 16'h0001;
  end
  ////////////////////////////////////////////////////////////////
  // two sync flops plus one register of slack
  sequence s_in_low_run;
    cmp_pins.input_low [*4];
  endsequence
  sequence s_batt_gone;
    !cmp_pins.ts_below_det [*3];
  endsequence
  sequence s_adp_gone;
    !cmp_pins.adapter_detect_pin_2v4 [*3];
  endsequence
  property p_bypass_drop; s_in_low_run |-> !bypass_switch; endproperty
  property p_bypass_rise; $rose(bypass_switch) |-> quiet_q >= DEGLITCH_CYCLES; endproperty
  property p_batt_gone; s_batt_gone |-> !charge_enable; endproperty
  property p_adp_gone; s_adp_gone |-> !five_volt_reference; endproperty
  property p_ref_charge; !five_volt_reference |-> !charge_enable; endproperty
  property p_port_charge; !host_port_enable |-> !charge_enable; endproperty
  property p_rd_refused; reg_rd_en && !host_port_enable |=> !reg_rd_valid; endproperty
  property p_rd_valid; reg_rd_en && host_port_enable |=> reg_rd_valid; endproperty
  property p_paths; !(battery_path_driver && adapter_path_driver); endproperty
  property p_round; regulated_voltage_mv != V_WAKE_MV |-> regulated_voltage_mv[3:0] == 4'h0;
  endproperty
  property p_cap; regulated_voltage_mv <= V_4C_MAX_MV; endproperty
  property p_alert_rise; $rose(alert) |-> up_q > ALERT_CYCLES; endproperty
  a_bypass_drop: assert property (p_bypass_drop) else $error("bypass stayed on");
  a_bypass_rise: assert property (p_bypass_rise) else $error("bypass back early");
  a_batt_gone: assert property (p_batt_gone) else $error("charge kept on");
  a_adp_gone: assert property (p_adp_gone) else $error("reference kept on");
  a_ref_charge: assert property (p_ref_charge) else $error("charge without adapter");
  a_port_charge: assert property (p_port_charge) else $error("charge before power on");
  a_rd_refused: assert property (p_rd_refused) else $error("read answered early");
  a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
  a_paths: assert property (p_paths) else $error("both paths on");
  a_round: assert property (p_round) else $error("setting not rounded down");
  a_cap: assert property (p_cap) else $error("regulation above max");
  a_alert_rise: assert property (p_alert_rise) else $error("alert too soon");
endmodule
bind csf_charger_status csf_charger_status_checker #(.DEGLITCH_CYCLES(DEGLITCH_CYCLES),
  .ALERT_CYCLES(ALERT_CYCLES)) csf_charger_status_checker_inst (.clk(clk), .resetn(resetn),
  .cmp_pins(cmp_pins), .reg_rd_en(reg_rd_en), .reg_rd_valid(reg_rd_valid),
  .host_port_enable(host_port_enable), .charge_enable(charge_enable),
  .regulated_voltage_mv(regulated_voltage_mv), .battery_path_driver(battery_path_driver),
  .adapter_path_driver(adapter_path_driver), .bypass_switch(bypass_switch),
  .five_volt_reference(five_volt_reference), .alert(alert));
`default_nettype wire

// ===== csf_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// host side of the register port; strobes last exactly one rising edge
module csf_host_model
  import csf_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rd_valid,
  output var logic [7:0]   reg_cmd,
  output var logic         reg_wr_en,
  output var logic [15:0]  reg_wdata,
  output var logic         reg_rd_en
);
  initial
  begin
    reg_cmd = 8'h00;
    reg_wr_en = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd_en = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(negedge clk);
    reg_cmd = c;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clk);
    reg_wr_en = 1'b0;
    reg_wdata = ~d;  // released data must not look valid
  endtask
  // answer is registered, so it is seen one cycle after the strobe
  task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic ok);
    @(negedge clk);
    reg_cmd = c;
    reg_rd_en = 1'b1;
    @(negedge clk);
    reg_rd_en = 1'b0;
    ok = reg_rd_valid;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ===== test_charger_status_flag_logic.sv
`timescale 1ns/1ns
`default_nettype none
module test_charger_status_flag_logic
  import csf_pkg::*;
;
  localparam int DG = 50;
  localparam int AL = 60;
  logic clk, resetn, reg_wr_en, reg_rd_en, reg_rd_valid, reg_cmd_ok, host_port_enable;
  logic charge_enable, battery_path_driver, adapter_path_driver, bypass_switch;
  logic five_volt_reference, alert;
  logic [15:0] bat_mv, reg_wdata, reg_rdata, reg_v;
  logic [7:0] reg_cmd;
  csf_cmp_type cmp;
  int err_count = 0;
  int compares = 0;
  csf_charger_status #(.DEGLITCH_CYCLES(DG), .ALERT_CYCLES(AL)) csf_charger_status_inst (
    .clk(clk), .resetn(resetn), .cmp_pins(cmp), .battery_sense_mv(bat_mv),
    .reg_cmd(reg_cmd), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .reg_cmd_ok(reg_cmd_ok),
    .host_port_enable(host_port_enable), .charge_enable(charge_enable),
    .regulated_voltage_mv(reg_v), .battery_path_driver(battery_path_driver),
    .adapter_path_driver(adapter_path_driver), .bypass_switch(bypass_switch),
    .five_volt_reference(five_volt_reference), .alert(alert));
  csf_host_model csf_host_model_inst (.clk(clk), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .reg_cmd(reg_cmd), .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // a wait that ran out ends the run
  task automatic tmo(input logic ok);
    if (ok !== 1'b1)
    begin
      chk("wait", 16'(ok), 16'h0001);
      final_report();
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_power();
    logic [15:0] d;
    logic ok;
    int i;
    csf_host_model_inst.wr(CMD_CONTROL, 16'h0010);
    csf_host_model_inst.rd(CMD_CONTROL, d, ok);
    chk("early read", 16'(ok), 16'h0000);
    chk("early ack", 16'(reg_cmd_ok), 16'h0000);
    chk("early charge", 16'(charge_enable), 16'h0000);
    cmp.adapter_detect_pin_1v2 = 1'b1;
    cmp.vcc_6v5 = 1'b1;
    for (i = 0; i < 300 && host_port_enable !== 1'b1; i++) @(negedge clk);
    tmo(host_port_enable);
    chk("release delay", 16'(i >= 100 && i <= 106), 16'h0001);
    csf_host_model_inst.rd(CMD_CONTROL, d, ok);
    chk("early write", d, 16'h0000);
    $display("done power");
  endtask
  task automatic t_flags();
    logic [15:0] d;
    logic ok;
    chk("ref off", 16'(five_volt_reference), 16'h0000);
    cmp.adapter_detect_pin_2v4 = 1'b1;
    cmp.ts_below_det = 1'b1;
    cmp.bat_above_acp = 1'b1;
    repeat (4) @(negedge clk);
    csf_host_model_inst.rd(CMD_STATUS, d, ok);
    chk("status", d, 16'hF000);
    chk("ref on", 16'(five_volt_reference), 16'h0001);
    csf_host_model_inst.wr(CMD_STATUS, 16'h0000);
    csf_host_model_inst.rd(CMD_STATUS, d, ok);
    chk("status kept", d, 16'hF000);
    chk("status ack", 16'(reg_cmd_ok), 16'h0001);
    csf_host_model_inst.rd(8'h77, d, ok);
    chk("unknown", {d[15:1], ok}, 16'h0001);
    chk("unknown ack", 16'(reg_cmd_ok), 16'h0000);
    $display("done flags");
  endtask
  task automatic t_volt();
    logic [15:0] vs[8] = '{16'h2328, 16'h2EE7, 16'h3840, 16'h3E8F,
                           16'h4E20, 16'h2AF8, 16'h3A98, 16'h2329};
    logic [15:0] vr[8] = '{16'h2328, 16'h2EE0, 16'h3840, 16'h3E80,
                           16'h4B00, 16'h0000, 16'h0000, 16'h0000};
    logic [7:0] voltage_out_of_range_flag = 8'b1111_0000;
    logic [7:0] ce = 8'b0001_1111;
    logic [15:0] d;
    logic ok;
    for (int k = 0; k < 8; k++)
    begin
      csf_host_model_inst.wr(CMD_CHARGE_VOLT, vs[k]);
      repeat (3) @(negedge clk);
      chk("regulated", reg_v, vr[k]);
      chk("charge", 16'(charge_enable), 16'(ce[k]));
      csf_host_model_inst.rd(CMD_STATUS, d, ok);
      chk("range flag", 16'(d[12]), 16'(voltage_out_of_range_flag[k]));
    end
    $display("done voltage");
  endtask
  task automatic t_deplete();
    logic [15:0] vs[3] = '{16'h2EE0, 16'h2EE0, 16'h3E80};
    logic [15:0] bs[3] = '{16'h21FB, 16'h21FC, 16'h2D4F};
    logic [2:0] dp = 3'b101;
    logic [15:0] d;
    logic ok;
    csf_host_model_inst.wr(CMD_CONTROL, 16'h0410);  // select 2, learn on
    for (int k = 0; k < 3; k++)
    begin
      csf_host_model_inst.wr(CMD_CHARGE_VOLT, vs[k]);
      bat_mv = bs[k];
      repeat (3) @(negedge clk);
      csf_host_model_inst.rd(CMD_STATUS, d, ok);
      chk("depleted", 16'(d[11]), 16'(dp[k]));
      chk("adapter path", 16'(adapter_path_driver), 16'(dp[k]));
      chk("battery path", 16'(battery_path_driver), 16'(!dp[k]));
    end
    $display("done depleted");
  endtask
  task automatic t_remove();
    bat_mv = 16'h3000;
    repeat (3) @(negedge clk);
    chk("charge on", 16'(charge_enable), 16'h0001);
    cmp.ts_below_det = 1'b0;
    repeat (3) @(negedge clk);
    chk("charge off", 16'(charge_enable), 16'h0000);
    cmp.ts_below_det = 1'b1;
    $display("done removal");
  endtask
  task automatic t_bypass();
    int i;
    chk("bypass idle", 16'(bypass_switch), 16'h0001);
    cmp.input_low = 1'b1;
    repeat (4) @(negedge clk);
    chk("bypass drop", 16'(bypass_switch), 16'h0000);
    cmp.input_low = 1'b0;
    repeat (40) @(negedge clk);
    chk("bypass held", 16'(bypass_switch), 16'h0000);
    for (i = 0; i < 30 && bypass_switch !== 1'b1; i++) @(negedge clk);
    tmo(bypass_switch);
    $display("done bypass");
  endtask
  task automatic t_alert();
    logic [15:0] d;
    logic ok;
    int i;
    repeat (AL + 10) @(negedge clk);
    csf_host_model_inst.rd(CMD_STATUS, d, ok);
    chk("alert clear", 16'(alert), 16'h0000);
    cmp.bat_above_acp = 1'b0;
    for (i = 0; i < 100 && alert !== 1'b1; i++) @(negedge clk);
    tmo(alert);
    chk("alert delay", 16'(i >= AL && i <= AL + 6), 16'h0001);
    csf_host_model_inst.rd(CMD_STATUS, d, ok);
    chk("alert read", 16'(alert), 16'h0000);
    $display("done alert");
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    resetn = 1'b0;
    cmp = '0;
    bat_mv = 16'h3000;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    t_power();
    t_flags();
    t_volt();
    t_deplete();
    t_remove();
    t_bypass();
    t_alert();
    final_report();
  end
endmodule
`default_nettype wire
